// ===== bench/ptr_cpu_model.sv
// processor-side register bus master model
`timescale 1ns/1ns
module ptr_cpu_model
(
	input wire logic clk_i,
	output logic [15:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [31:0] reg_wdata_o,
	input wire logic [31:0] reg_rdata_i,
	input wire logic reg_ack_i
);
	initial
	begin
		reg_addr_o = 16'h0000;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 32'h0000_0000;
	end
	// strobe is a one-cycle pulse; address and data held until the ack edge
	task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		int n;
		ok = 1'b0;
		@(posedge clk_i);
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= w;
		reg_rd_o <= !w;
		@(posedge clk_i);
		reg_wr_o <= 1'b0;
		reg_rd_o <= 1'b0;
		for (n = 0; n < 4 && ok !== 1'b1; n++)
		begin
			@(posedge clk_i);
			ok = reg_ack_i;
		end
		q = reg_rdata_i;
		// released lines show junk, not the last value
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
	endtask
endmodule

// ===== bench/ptr_rtc_regs_asserts.sv
// port-level assertions for the time counter register block
`timescale 1ns/1ns
module ptr_rtc_regs_chk
	import ptr_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic reg_ack_o,
	input wire logic [NS_W-1:0] rtc_ns_o,
	input wire logic [SEC_W-1:0] rtc_sec_o,
	input wire logic timer_irq_o,
	input wire logic eight_khz_timing_out_o,
	input wire logic tx_reset_o,
	input wire logic rx_reset_o,
	input wire logic ptp_tx_reset_o,
	input wire logic ptp_rx_reset_o
);
	// ****************************************
	// helpers
	// ****************************************
	logic wr_ns, wr_clr, wr_rst, rd_ok, rd_now;
	logic [SEC_W-1:0] ofs_ff, cap_ff;
	assign wr_ns = reg_wr_i && reg_addr_i == OFS_NS_OFFSET;
	assign wr_clr = reg_wr_i && reg_addr_i == OFS_IRQ_CLEAR;
	assign wr_rst = reg_wr_i && reg_addr_i == OFS_SOFT_RESET;
	assign rd_ok = reg_rd_i && !reg_wr_i;
	assign rd_now = rd_ok && reg_addr_i == OFS_NS_NOW;
	// pending seconds, what the next load must apply
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			ofs_ff <= '0;
		else if (reg_wr_i && reg_addr_i == OFS_SEC_OFFSET_LOW)
			ofs_ff[31:0] <= reg_wdata_i;
		else if (reg_wr_i && reg_addr_i == OFS_SEC_OFFSET_HIGH)
			ofs_ff[SEC_W-1:32] <= reg_wdata_i[15:0];
	end
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			cap_ff <= '0;
		else if (rd_now)
			cap_ff <= rtc_sec_o;
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	AST_LOAD: assert property (
		wr_ns |=> rtc_sec_o == ofs_ff
		&& {2'b00, rtc_ns_o} == ($past(reg_wdata_i) & 32'h3FFF_FFFF))
		else $error("offset load wrong");
	AST_SEC_STEP: assert property (
		$changed(rtc_sec_o) |-> $past(wr_ns) || rtc_sec_o == $past(rtc_sec_o) + 48'h1)
		else $error("seconds moved without cause");
	AST_CARRY: assert property (
		!$past(wr_ns) && rtc_sec_o == $past(rtc_sec_o) + 48'h1 |-> rtc_ns_o < $past(rtc_ns_o))
		else $error("carry without wrap");
	AST_NS_RD: assert property (
		rd_now |=> reg_ack_o && reg_rdata_o == {2'b00, $past(rtc_ns_o)})
		else $error("nanoseconds read wrong");
	AST_SEC_RD: assert property (
		rd_ok && (reg_addr_i == OFS_SEC_NOW_LOW || reg_addr_i == OFS_SEC_NOW_HIGH)
		|=> reg_rdata_o == ($past(reg_addr_i) == OFS_SEC_NOW_HIGH ?
		{16'h0000, cap_ff[SEC_W-1:32]} : cap_ff[31:0]))
		else $error("seconds read not the capture");
	AST_IRQ_HOLD: assert property (
		$fell(timer_irq_o) |-> $past(wr_clr))
		else $error("interrupt dropped by itself");
	// a period event in the clearing cycle wins; the wave then rises one cycle later
	AST_IRQ_CLR: assert property (
		wr_clr |=> (!timer_irq_o or ##1 $rose(eight_khz_timing_out_o)))
		else $error("interrupt not cleared");
	AST_WO_RD: assert property (
		rd_ok && (reg_addr_i == OFS_IRQ_CLEAR || reg_addr_i == OFS_SOFT_RESET)
		|=> reg_rdata_o == 32'h0000_0000)
		else $error("write-only register read nonzero");
	AST_TX_RST: assert property (
		wr_rst && reg_wdata_i[0] |=> (tx_reset_o && ptp_tx_reset_o) [*8])
		else $error("transmit reset missing");
	AST_RX_RST: assert property (
		wr_rst && reg_wdata_i[1] |=> (rx_reset_o && ptp_rx_reset_o) [*8])
		else $error("receive reset missing");
	AST_PTX_CAUSE: assert property (
		$rose(ptp_tx_reset_o) |-> $past(wr_rst) && ($past(reg_wdata_i) & 32'h5) != 32'h0)
		else $error("timing tx reset without request");
	AST_PRX_CAUSE: assert property (
		$rose(ptp_rx_reset_o) |-> $past(wr_rst) && ($past(reg_wdata_i) & 32'hA) != 32'h0)
		else $error("timing rx reset without request");
endmodule

// ===== bench/ptr_rtc_regs_tb.sv
// self-checking bench for the time counter register block
`timescale 1ns/1ns
module ptr_rtc_regs_tb
	import ptr_pkg::*;
;
	logic clk_i, resetn_i, reg_wr_i, reg_rd_i, reg_ack_o, timer_irq_o, ek_o;
	logic tx_reset_o, rx_reset_o, ptp_tx_reset_o, ptp_rx_reset_o, ok;
	logic [15:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, rdq;
	logic [NS_W-1:0] rtc_ns_o;
	logic [SEC_W-1:0] rtc_sec_o;
	int fail_count, n_compared;
	ptr_rtc_regs i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .rtc_ns_o(rtc_ns_o),
		.rtc_sec_o(rtc_sec_o), .timer_irq_o(timer_irq_o), .eight_khz_timing_out_o(ek_o),
		.tx_reset_o(tx_reset_o), .rx_reset_o(rx_reset_o),
		.ptp_tx_reset_o(ptp_tx_reset_o), .ptp_rx_reset_o(ptp_rx_reset_o));
	ptr_cpu_model i_cpu (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
		.reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
		.reg_ack_i(reg_ack_o));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic close_out();
		if (fail_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		i_cpu.access(w, a, d, rdq, ok);
		if (ok !== 1'b1)
		begin
			fail_count++;
			close_out();
		end
	endtask
	task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, e, rdq);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		logic [15:0] ofs [11];
		logic [31:0] exp [11];
		ofs = '{OFS_NS_OFFSET, OFS_SEC_OFFSET_LOW, OFS_SEC_OFFSET_HIGH, OFS_TIME_INCREMENT,
			OFS_NS_NOW, OFS_SEC_NOW_LOW, OFS_SEC_NOW_HIGH, OFS_IRQ_CLEAR, OFS_PHASE_ADJUST,
			OFS_SOFT_RESET, 16'h2830};
		exp = '{32'h0, 32'hFFFF_FFFF, 32'h0000_FFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
			32'h3FFF_FFFF, 32'h0, 32'h0};
		for (int i = 0; i < 11; i++)
			rdc("reset value", ofs[i], 32'h0000_0000);
		for (int i = 1; i < 11; i++)
			if (i != 3)
				bus(1'b1, ofs[i], 32'hFFFF_FFFF);
		for (int i = 0; i < 11; i++)
			rdc("access", ofs[i], exp[i]);
		chk("sec pending", 48'h0, rtc_sec_o);
	endtask
	task automatic t_count();
		bus(1'b1, OFS_TIME_INCREMENT, 32'hFD40_0000);
		rdc("increment", OFS_TIME_INCREMENT, 32'h0140_0000);
		bus(1'b1, OFS_SEC_OFFSET_LOW, 32'h1234_5678);
		bus(1'b1, OFS_SEC_OFFSET_HIGH, 32'hFFFF_ABCD);
		chk("sec still", 48'h0, rtc_sec_o);
		bus(1'b1, OFS_NS_OFFSET, 32'h3B9A_C9D8);
		chk("ns load", 30'h3B9A_C9D8, rtc_ns_o);
		chk("sec load", 48'hABCD_1234_5678, rtc_sec_o);
		repeat (10) @(posedge clk_i);
		chk("ns wrap", 30'h3C, rtc_ns_o);
		chk("sec carry", 48'hABCD_1234_5679, rtc_sec_o);
	endtask
	task automatic t_sample();
		bus(1'b1, OFS_TIME_INCREMENT, 32'h0);
		bus(1'b1, OFS_NS_OFFSET, 32'd123);
		rdc("ns now", OFS_NS_NOW, 32'd123);
		rdc("sec low", OFS_SEC_NOW_LOW, 32'h1234_5678);
		rdc("sec high", OFS_SEC_NOW_HIGH, 32'h0000_ABCD);
		bus(1'b1, OFS_SEC_OFFSET_LOW, 32'h0);
		bus(1'b1, OFS_NS_OFFSET, 32'd5);
		rdc("sec static", OFS_SEC_NOW_LOW, 32'h1234_5678);
		rdc("ns now 2", OFS_NS_NOW, 32'd5);
		rdc("sec low 2", OFS_SEC_NOW_LOW, 32'h0);
	endtask
	task automatic t_wave();
		int n;
		bus(1'b1, OFS_TIME_INCREMENT, 32'h0140_0000);
		bus(1'b1, OFS_PHASE_ADJUST, 32'h0);
		bus(1'b1, OFS_NS_OFFSET, 32'h0);
		repeat (10) @(posedge clk_i);
		chk("wave zero phase", 1'b1, ek_o);
		bus(1'b1, OFS_PHASE_ADJUST, 32'h0000_F424);
		repeat (10) @(posedge clk_i);
		chk("wave before load", 1'b1, ek_o);
		bus(1'b1, OFS_NS_OFFSET, 32'h0);
		repeat (10) @(posedge clk_i);
		chk("wave half phase", 1'b0, ek_o);
		for (n = 0; n < 7000 && timer_irq_o !== 1'b1; n++)
			@(posedge clk_i);
		chk("irq set", 1'b1, timer_irq_o);
		if (n == 7000)
			close_out();
		repeat (50) @(posedge clk_i);
		chk("irq held", 1'b1, timer_irq_o);
		bus(1'b1, OFS_IRQ_CLEAR, 32'h0);
		chk("irq cleared", 1'b0, timer_irq_o);
	endtask
	task automatic t_srst();
		logic [3:0] dat [8];
		logic [3:0] exp [8];
		dat = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'hA, 4'hF, 4'h0};
		exp = '{4'hA, 4'h5, 4'h2, 4'h1, 4'hA, 4'h5, 4'hF, 4'h0};
		for (int i = 0; i < 8; i++)
		begin
			repeat (20) @(posedge clk_i);
			bus(1'b1, OFS_SOFT_RESET, {28'h0, dat[i]});
			chk("resets on", exp[i], {tx_reset_o, rx_reset_o, ptp_tx_reset_o,
				ptp_rx_reset_o});
			repeat (16) @(posedge clk_i);
			chk("resets off", 4'h0, {tx_reset_o, rx_reset_o, ptp_tx_reset_o,
				ptp_rx_reset_o});
		end
		rdc("config kept", OFS_TIME_INCREMENT, 32'h0140_0000);
	endtask
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial
	begin
		fail_count = 0;
		n_compared = 0;
		resetn_i = 1'b0;
		repeat (4) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_regs();
		t_count();
		t_sample();
		t_wave();
		t_srst();
		close_out();
	end
endmodule
bind ptr_rtc_regs ptr_rtc_regs_chk i_chk (.clk_i(clk_i), .resetn_i(resetn_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
	.rtc_ns_o(rtc_ns_o), .rtc_sec_o(rtc_sec_o), .timer_irq_o(timer_irq_o),
	.eight_khz_timing_out_o(eight_khz_timing_out_o),
	.tx_reset_o(tx_reset_o), .rx_reset_o(rx_reset_o), .ptp_tx_reset_o(ptp_tx_reset_o),
	.ptp_rx_reset_o(ptp_rx_reset_o));

// ===== logic/ptr_eightk_gen.sv
// 8 kHz timing signal generator with phase load
`timescale 1ns/1ns
module ptr_eightk_gen
	import ptr_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic tick_i,
	input wire logic [INC_W-1:0] inc_i,
	input wire logic load_i,
	input wire logic [NS_W-1:0] ns_load_i,
	input wire logic [PHASE_W-1:0] phase_i,
	output logic wave_o,
	output logic period_o
);

	logic [EK_W-1:0] whole_ff;
	logic [FRAC_W-1:0] frac_ff;
	logic [EK_W-1:0] nxt_whole;
	logic [FRAC_W-1:0] nxt_frac;
	logic wrap;
	logic [EK_W+FRAC_W:0] sum;
	logic [NS_W:0] load_sum;
	logic [EK_W-1:0] load_pos;

	// 1e9 is a whole number of 8 kHz periods, so tracking ns modulo the
	// period keeps phase across seconds rollover
	always_comb
	begin
		sum = {1'b0, whole_ff, frac_ff} + {{(EK_W+1-(INC_W-FRAC_W)){1'b0}}, inc_i};
		wrap = (sum[EK_W+FRAC_W:FRAC_W] >= {1'b0, EK_PERIOD_NS});
		nxt_frac = sum[FRAC_W-1:0];
		if (wrap)
		begin
			nxt_whole = EK_W'(sum[EK_W+FRAC_W:FRAC_W] - {1'b0, EK_PERIOD_NS});
		end
		else
		begin
			nxt_whole = sum[EK_W+FRAC_W-1:FRAC_W];
		end
		load_sum = {1'b0, ns_load_i} + {1'b0, phase_i};
		load_pos = EK_W'(load_sum % (NS_W+1)'(EK_PERIOD_NS));
	end

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			whole_ff <= '0;
			frac_ff <= '0;
		end
		else if (load_i)
		begin
			whole_ff <= load_pos; // [RQ10]
			frac_ff <= '0;
		end
		else if (tick_i)
		begin
			whole_ff <= nxt_whole;
			frac_ff <= nxt_frac;
		end
	end

	// the wave falls where the phase-shifted count crosses half a period and rises where it wraps
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			wave_o <= 1'b0;
			period_o <= 1'b0;
		end
		else
		begin
			wave_o <= (whole_ff < EK_HALF_NS); // [RQ11]
			period_o <= tick_i && !load_i && wrap;
		end
	end

endmodule

// ===== logic/ptr_pkg.sv
// constants for the precision time counter register block
package ptr_pkg;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [15:0] OFS_NS_OFFSET = 16'h2800;
	localparam logic [15:0] OFS_SEC_OFFSET_LOW = 16'h2808;
	localparam logic [15:0] OFS_SEC_OFFSET_HIGH = 16'h280C;
	localparam logic [15:0] OFS_TIME_INCREMENT = 16'h2810;
	localparam logic [15:0] OFS_NS_NOW = 16'h2814;
	localparam logic [15:0] OFS_SEC_NOW_LOW = 16'h2818;
	localparam logic [15:0] OFS_SEC_NOW_HIGH = 16'h281C;
	localparam logic [15:0] OFS_IRQ_CLEAR = 16'h2820;
	localparam logic [15:0] OFS_PHASE_ADJUST = 16'h2824;
	localparam logic [15:0] OFS_SOFT_RESET = 16'h2828;

	// ************************************************************
	// field widths and positions
	// ************************************************************
	localparam int NS_W = 30;
	localparam int SEC_W = 48;
	localparam int SEC_LOW_W = 32;
	localparam int SEC_HIGH_W = 16;
	localparam int FRAC_W = 20;
	localparam int INC_W = 26;
	localparam int PHASE_W = 30;
	localparam int EK_W = 17;
	localparam int IRQ_CLEAR_BIT = 0;
	localparam int SRST_TX_BIT = 0;
	localparam int SRST_RX_BIT = 1;
	localparam int SRST_PTP_TX_BIT = 2;
	localparam int SRST_PTP_RX_BIT = 3;
	localparam int SRST_N = 4;

	// ************************************************************
	// reset values and time constants
	// ************************************************************
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [NS_W-1:0] NS_PER_SEC = 30'h3B9A_CA00;
	localparam logic [EK_W-1:0] EK_PERIOD_NS = 17'h1_E848;
	localparam logic [EK_W-1:0] EK_HALF_NS = 17'h0_F424;
	localparam int CLK_PERIOD_NS = 10;
	localparam int REF_PERIOD_NS = 20;
	localparam int REF_DIV = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SRST_PULSE_NS = 160;
	localparam int SRST_PULSE_CYC = (SRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIV_W = 4;
	localparam int SRST_CNT_W = 8;

endpackage

// ===== logic/ptr_rtc_regs.sv
// precision time counter with offset, sample, interrupt, phase and reset registers
`timescale 1ns/1ns
// What this block does
// [RQ1] seconds offset writes wait; the nanosecond offset write applies all together
// [RQ2] 30-bit nanosecond offset register; its write loads all three offsets
// [RQ3] software sets initial time or steps corrections through the offsets
// [RQ4] every reference tick adds a 26-bit increment in 2^-20 ns units
// [RQ5] software programs increment as reference period; reference above 25 MHz
// [RQ6] nanoseconds read returns live count and captures both seconds words
// [RQ7] seconds reads return the value captured at the last nanoseconds read
// [RQ8] periodic timer interrupt stays high until software clears it
// [RQ9] any write to clear register drops interrupt; bit reads zero
// [RQ10] phase value loads into 8 kHz generator with the offset load
// [RQ11] 8 kHz output shifted by phase in 1 ns steps
// [RQ12] reset bit 0 resets transmit path, asserts transmit reset, reads zero
// [RQ13] reset bit 1 resets receive path, asserts receive reset, reads zero
// [RQ14] reset bit 2 resets only timing-protocol transmit logic
// [RQ15] reset bit 3 resets only timing-protocol receive logic
// [RQ16] any combination of reset bits acts together; others untouched
// [RQ17] nanoseconds wrap at one billion and carry into seconds
// [RQ18] multi-bit values move into the counter without tearing
module ptr_rtc_regs
	import ptr_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	output logic reg_ack_o,
	output logic [NS_W-1:0] rtc_ns_o,
	output logic [SEC_W-1:0] rtc_sec_o,
	output logic timer_irq_o,
	output logic eight_khz_timing_out_o,
	output logic tx_reset_o,
	output logic rx_reset_o,
	output logic ptp_tx_reset_o,
	output logic ptp_rx_reset_o
);

	// ************************************************************
	// declarations
	// ************************************************************
	logic [SEC_LOW_W-1:0] sec_off_low_ff;
	logic [SEC_HIGH_W-1:0] sec_off_high_ff;
	logic [NS_W-1:0] ns_off_ff;
	logic [INC_W-1:0] incr_ff;
	logic [PHASE_W-1:0] phase_ff;
	logic [SEC_W-1:0] sec_ff;
	logic [NS_W-1:0] ns_ff;
	logic [FRAC_W-1:0] frac_ff;
	logic [SEC_W-1:0] sec_cap_ff;
	logic [DIV_W-1:0] div_cnt_ff;
	logic tick_ff;
	logic irq_ff;
	logic [31:0] rdata_ff;
	logic ack_ff;
	logic wr_go;
	logic rd_go;
	logic ns_load;
	logic irq_clear;
	logic srst_wr;
	logic [SRST_N-1:0] srst_req;
	logic [SRST_N-1:0] srst_active;
	logic [31:0] nxt_rdata;
	logic [NS_W+FRAC_W:0] acc_sum;
	logic [NS_W:0] acc_whole;
	logic carry;
	logic [NS_W-1:0] nxt_ns;
	logic [FRAC_W-1:0] nxt_frac;
	logic ek_wave;
	logic ek_period;

	// ************************************************************
	// access decode
	// ************************************************************
	// a write wins when both strobes are raised together
	assign wr_go = reg_wr_i;
	assign rd_go = reg_rd_i && !reg_wr_i;
	assign ns_load = wr_go && (reg_addr_i == OFS_NS_OFFSET); // [RQ2]
	assign irq_clear = wr_go && (reg_addr_i == OFS_IRQ_CLEAR); // [RQ9]
	assign srst_wr = wr_go && (reg_addr_i == OFS_SOFT_RESET);

	// ************************************************************
	// writable configuration
	// ************************************************************
	// seconds offsets only park here; nothing reaches the counter yet
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			sec_off_low_ff <= REG_RESET[SEC_LOW_W-1:0];
			sec_off_high_ff <= REG_RESET[SEC_HIGH_W-1:0];
		end
		else if (wr_go && reg_addr_i == OFS_SEC_OFFSET_LOW)
		begin
			sec_off_low_ff <= reg_wdata_i; // [RQ1]
		end
		else if (wr_go && reg_addr_i == OFS_SEC_OFFSET_HIGH)
		begin
			sec_off_high_ff <= reg_wdata_i[SEC_HIGH_W-1:0]; // [RQ1]
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			ns_off_ff <= REG_RESET[NS_W-1:0];
		end
		else if (ns_load)
		begin
			ns_off_ff <= reg_wdata_i[NS_W-1:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			incr_ff <= REG_RESET[INC_W-1:0];
		end
		else if (wr_go && reg_addr_i == OFS_TIME_INCREMENT)
		begin
			incr_ff <= reg_wdata_i[INC_W-1:0]; // [RQ4]
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			phase_ff <= REG_RESET[PHASE_W-1:0];
		end
		else if (wr_go && reg_addr_i == OFS_PHASE_ADJUST)
		begin
			phase_ff <= reg_wdata_i[PHASE_W-1:0];
		end
	end

	// ************************************************************
	// reference tick
	// ************************************************************
	// reference rate is an enable from a divider, so offsets, increment
	// and phase are used in the same clock and never tear
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			div_cnt_ff <= '0;
			tick_ff <= 1'b0;
		end
		else if (div_cnt_ff == DIV_W'(REF_DIV - 1))
		begin
			div_cnt_ff <= '0;
			tick_ff <= 1'b1;
		end
		else
		begin
			div_cnt_ff <= div_cnt_ff + 1'b1;
			tick_ff <= 1'b0;
		end
	end

	// ************************************************************
	// time counter
	// ************************************************************
	// increment tops out near 64 ns, so one subtraction always suffices
	always_comb
	begin
		acc_sum = {1'b0, ns_ff, frac_ff}
			+ {{(NS_W+1-(INC_W-FRAC_W)){1'b0}}, incr_ff}; // [RQ4]
		acc_whole = acc_sum[NS_W+FRAC_W:FRAC_W];
		carry = (acc_whole >= {1'b0, NS_PER_SEC});
		nxt_frac = acc_sum[FRAC_W-1:0];
		if (carry)
		begin
			nxt_ns = NS_W'(acc_whole - {1'b0, NS_PER_SEC}); // [RQ17]
		end
		else
		begin
			nxt_ns = acc_whole[NS_W-1:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			sec_ff <= '0;
			ns_ff <= '0;
			frac_ff <= '0;
		end
		else if (ns_load)
		begin
			sec_ff <= {sec_off_high_ff, sec_off_low_ff}; // [RQ1]
			ns_ff <= reg_wdata_i[NS_W-1:0]; // [RQ2]
			frac_ff <= '0; // [RQ18]
		end
		else if (tick_ff)
		begin
			ns_ff <= nxt_ns;
			frac_ff <= nxt_frac;
			if (carry)
			begin
				sec_ff <= sec_ff + 1'b1; // [RQ17]
			end
		end
	end

	// ************************************************************
	// 8 kHz timing signal
	// ************************************************************
	ptr_eightk_gen u_eightk (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.tick_i(tick_ff),
		.inc_i(incr_ff),
		.load_i(ns_load), // [RQ10]
		.ns_load_i(reg_wdata_i[NS_W-1:0]),
		.phase_i(phase_ff),
		.wave_o(ek_wave),
		.period_o(ek_period)
	);

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			eight_khz_timing_out_o <= 1'b0;
		end
		else
		begin
			eight_khz_timing_out_o <= ek_wave; // [RQ11]
		end
	end

	// ************************************************************
	// periodic timer interrupt
	// ************************************************************
	// a period event in the clearing cycle wins, so no period is lost
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			irq_ff <= 1'b0;
		end
		else if (ek_period)
		begin
			irq_ff <= 1'b1; // [RQ8]
		end
		else if (irq_clear)
		begin
			irq_ff <= 1'b0; // [RQ9]
		end
	end

	assign timer_irq_o = irq_ff;

	// ************************************************************
	// software resets
	// ************************************************************
	// a full path reset also covers its timing-protocol subset
	always_comb
	begin
		srst_req = '0;
		if (srst_wr)
		begin
			srst_req[SRST_TX_BIT] = reg_wdata_i[SRST_TX_BIT]; // [RQ12]
			srst_req[SRST_RX_BIT] = reg_wdata_i[SRST_RX_BIT]; // [RQ13]
			srst_req[SRST_PTP_TX_BIT] = reg_wdata_i[SRST_PTP_TX_BIT]
				|| reg_wdata_i[SRST_TX_BIT]; // [RQ14]
			srst_req[SRST_PTP_RX_BIT] = reg_wdata_i[SRST_PTP_RX_BIT]
				|| reg_wdata_i[SRST_RX_BIT]; // [RQ15]
		end
	end

	// each function has its own stretcher, so any mix runs in parallel
	genvar gi;
	generate
		for (gi = 0; gi < SRST_N; gi++)
		begin : g_srst
			logic [SRST_CNT_W-1:0] cnt_ff;
			logic act_ff;
			always_ff @(posedge clk_i)
			begin
				if (!resetn_i)
				begin
					cnt_ff <= '0;
					act_ff <= 1'b0;
				end
				else if (srst_req[gi])
				begin
					cnt_ff <= SRST_CNT_W'(SRST_PULSE_CYC - 1); // [RQ16]
					act_ff <= 1'b1;
				end
				else if (cnt_ff != '0)
				begin
					cnt_ff <= cnt_ff - 1'b1;
					act_ff <= 1'b1;
				end
				else
				begin
					act_ff <= 1'b0;
				end
			end
			assign srst_active[gi] = act_ff;
		end
	endgenerate

	assign tx_reset_o = srst_active[SRST_TX_BIT];
	assign rx_reset_o = srst_active[SRST_RX_BIT];
	assign ptp_tx_reset_o = srst_active[SRST_PTP_TX_BIT];
	assign ptp_rx_reset_o = srst_active[SRST_PTP_RX_BIT];

	// ************************************************************
	// sampled seconds
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			sec_cap_ff <= '0;
		end
		else if (rd_go && reg_addr_i == OFS_NS_NOW)
		begin
			sec_cap_ff <= sec_ff; // [RQ6]
		end
	end

	// ************************************************************
	// read data
	// ************************************************************
	// write-only bits and unmapped offsets read as zero
	always_comb
	begin
		nxt_rdata = '0;
		case (reg_addr_i)
			OFS_NS_OFFSET:
				nxt_rdata[NS_W-1:0] = ns_off_ff;
			OFS_SEC_OFFSET_LOW:
				nxt_rdata = sec_off_low_ff;
			OFS_SEC_OFFSET_HIGH:
				nxt_rdata[SEC_HIGH_W-1:0] = sec_off_high_ff;
			OFS_TIME_INCREMENT:
				nxt_rdata[INC_W-1:0] = incr_ff;
			OFS_NS_NOW:
				nxt_rdata[NS_W-1:0] = ns_ff; // [RQ6]
			OFS_SEC_NOW_LOW:
				nxt_rdata = sec_cap_ff[SEC_LOW_W-1:0]; // [RQ7]
			OFS_SEC_NOW_HIGH:
				nxt_rdata[SEC_HIGH_W-1:0] = sec_cap_ff[SEC_W-1:SEC_LOW_W]; // [RQ7]
			OFS_PHASE_ADJUST:
				nxt_rdata[PHASE_W-1:0] = phase_ff;
			default:
				nxt_rdata = '0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			rdata_ff <= '0;
			ack_ff <= 1'b0;
		end
		else
		begin
			ack_ff <= wr_go || rd_go;
			if (rd_go)
			begin
				rdata_ff <= nxt_rdata;
			end
			else
			begin
				rdata_ff <= '0;
			end
		end
	end

	assign reg_rdata_o = rdata_ff;
	assign reg_ack_o = ack_ff;
	assign rtc_ns_o = ns_ff;
	assign rtc_sec_o = sec_ff;

endmodule
